// file: core/cdr_mgmt_pkg.sv
package cdr_mgmt_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 20;
  localparam int SCL_PERIOD_NS = 640;
  localparam int QUARTER_CYCLES = SCL_PERIOD_NS / 4 / CLK_PERIOD_NS;
  localparam int QUARTER_W = 4;

  // ****************************************
  // Serial bus addressing
  // ****************************************
  localparam logic [6:0] SLAVE_ADDR_BASE = 7'h40;
  localparam int SLAVE_ADDR_SEL_BIT = 5;
  localparam logic [3:0] BYTE_LAST_BIT = 4'h7;
  localparam logic [3:0] ACK_BIT = 4'h8;

  // ****************************************
  // Device register map
  // ****************************************
  localparam logic [7:0] FREQ_LOW_ADDR = 8'h00;
  localparam logic [7:0] FREQ_MID_ADDR = 8'h01;
  localparam logic [7:0] FREQ_HIGH_ADDR = 8'h02;
  localparam logic [7:0] RATE_ADDR = 8'h03;
  localparam logic [7:0] STATUS_ADDR = 8'h04;
  localparam logic [7:0] REFERENCE_AND_MEASURE_CTRL_ADDR = 8'h08;
  localparam logic [7:0] LOCK_PIN_AND_RESET_CTRL_ADDR = 8'h09;
  localparam logic [7:0] SIGNAL_PIN_AND_SQUELCH_CTRL_ADDR = 8'h11;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int FREQ_W = 23;
  localparam int RATE_W = 9;
  localparam int SIGNAL_BIT = 5;
  localparam int LATCH_BIT = 4;
  localparam int ACQ_BIT = 3;
  localparam int DONE_BIT = 2;

  localparam int LOCK_REF_BIT = 0;
  localparam int MEASURE_BIT = 1;
  localparam int RATIO_LSB = 2;
  localparam int RATIO_MSB = 5;
  localparam int BAND_LSB = 6;
  localparam int BAND_MSB = 7;

  localparam int LOL_CFG_BIT = 7;
  localparam int CLR_LATCH_BIT = 6;
  localparam int SYS_RESET_BIT = 5;
  localparam int CLR_DONE_BIT = 3;
  localparam logic [7:0] LOCK_PIN_AND_RESET_CTRL_RESERVED_MASK = 8'h17;
  localparam logic [7:0] LOCK_PIN_AND_RESET_CTRL_PULSE_MASK = 8'h68;

  localparam int LOS_POL_BIT = 2;
  localparam int SQUELCH_MODE_BIT = 1;
  localparam logic [7:0] SIGNAL_PIN_AND_SQUELCH_CTRL_RESERVED_MASK = 8'hf9;

  // ****************************************
  // Host register map
  // ****************************************
  localparam int APB_ADDR_W = 12;
  localparam logic [11:0] HOST_CMD_OFFSET = 12'h000;
  localparam logic [11:0] HOST_STATUS_OFFSET = 12'h004;
  localparam int CMD_DATA_LSB = 8;
  localparam int CMD_READ_BIT = 16;
  localparam int CMD_ADDR_SEL_BIT = 17;
  localparam int CMD_PULSE_BIT = 18;
  localparam int HOST_BUSY_BIT = 0;
  localparam int HOST_NACK_BIT = 1;
  localparam int HOST_RDATA_LSB = 8;

  typedef enum logic [2:0] {
    SL_IDLE = 3'b000,
    SL_ADDR = 3'b001,
    SL_REG = 3'b011,
    SL_DATA = 3'b010,
    SL_SEND = 3'b110
  } slave_state_type;

  typedef enum logic [2:0] {
    M_IDLE = 3'b000,
    M_START = 3'b001,
    M_SEND = 3'b011,
    M_RESTART = 3'b010,
    M_RECV = 3'b110,
    M_STOP = 3'b111
  } master_state_type;

endpackage

// file: core/cdr_link_if.sv
`timescale 1ns/1ns
`default_nettype none
interface cdr_link_if;
  logic scl_out_host;
  logic scl_oe_host;
  logic sda_out_host;
  logic sda_oe_host;
  logic sda_out_device;
  logic sda_oe_device;
  wire scl;
  wire sda;

  // Open-drain wires: any enabled driver wins, otherwise the pull-up
  assign scl = ~(scl_oe_host & ~scl_out_host);
  assign sda = ~((sda_oe_host & ~sda_out_host) | (sda_oe_device & ~sda_out_device));

  modport host (output scl_out_host, scl_oe_host, sda_out_host, sda_oe_host, input scl, sda);
  modport device (output sda_out_device, sda_oe_device, input scl, sda);
endinterface
`default_nettype wire

// file: core/cdr_mgmt_device.sv
// Behaviour
// - frequency and coarse rate readback registers
// - status bit 3 shows acquiring
// - status bit 5 shows signal lost
// - bit 4 latches lock loss until cleared
// - bit 2 zero measuring, one complete
// - writing measure bit starts a measurement
// - bit 0 selects lock to reference
// - reference band and ratio exponent fields
// - control registers reset to zero
// - lock pin shows live or latched
// - one then zero clears latched flag
// - one then zero resets control registers, flags and readback
// - one then zero clears completion flag
// - host writes zero to reserved bits
// - squelch mode both or one output
// - signal lost pin polarity select
// - control registers are write only
// - squelch pin disables recovered outputs
// - dedicated lock lost pin, active high
// - address bit 5 from a pin
`timescale 1ns/1ns
`default_nettype none
module cdr_mgmt_device
  import cdr_mgmt_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  cdr_link_if.device link,
  input wire logic slave_addr_bit_select,
  input wire logic squelch,
  input wire logic input_signal_absent,
  input wire logic loop_acquiring,
  input wire logic measure_done,
  input wire logic [FREQ_W-1:0] freq_count,
  input wire logic [RATE_W-1:0] coarse_rate,
  output logic lock_lost,
  output logic signal_lost,
  output logic clock_out_enable,
  output logic data_out_enable,
  output logic lock_to_reference,
  output logic [1:0] reference_band,
  output logic [3:0] rate_ratio_exp,
  output logic measure_start,
  output logic system_reset
);

  // ****************************************
  // Input synchronisers
  // ****************************************
  localparam logic [6:0] SYNC_RESET = 7'h60;
  logic [6:0] raw;
  logic [6:0] meta;
  logic [6:0] sync;
  logic [3:0] prev;
  logic scl_s, sda_s, addr_sel_s, squelch_s, absent_s, acquiring_s, done_s;

  assign raw = {link.scl, link.sda, slave_addr_bit_select, squelch,
                input_signal_absent, loop_acquiring, measure_done};
  assign {scl_s, sda_s, addr_sel_s, squelch_s, absent_s, acquiring_s, done_s} = sync;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= SYNC_RESET;
      sync <= SYNC_RESET;
      prev <= 4'hc;
    end else begin
      meta <= raw;
      sync <= meta;
      prev <= {scl_s, sda_s, acquiring_s, done_s};
    end
  end

  logic scl_rise, scl_fall, bus_start, bus_stop, acq_rise, done_rise;
  assign scl_rise = scl_s & ~prev[3];
  assign scl_fall = ~scl_s & prev[3];
  assign bus_start = scl_s & prev[3] & prev[2] & ~sda_s;
  assign bus_stop = scl_s & prev[3] & ~prev[2] & sda_s;
  assign acq_rise = acquiring_s & ~prev[1];
  assign done_rise = done_s & ~prev[0];

  logic [6:0] my_addr;
  always_comb begin
    my_addr = SLAVE_ADDR_BASE;
    my_addr[SLAVE_ADDR_SEL_BIT] = addr_sel_s;
  end

  // ****************************************
  // Register storage
  // ****************************************
  logic [7:0] reference_and_measure_ctrl, lock_pin_and_reset_ctrl, signal_pin_and_squelch_ctrl;
  logic [FREQ_W-1:0] freq_hold;
  logic [RATE_W-1:0] rate_hold;
  logic done_flag, latched_lol, soft_reset;
  logic [7:0] status_byte, tx_next;
  logic [7:0] ptr;

  always_comb begin
    status_byte = 8'h00;
    status_byte[SIGNAL_BIT] = absent_s;
    status_byte[LATCH_BIT] = latched_lol;
    status_byte[ACQ_BIT] = acquiring_s;
    status_byte[DONE_BIT] = done_flag;
    status_byte[0] = rate_hold[0];
  end

  // Control registers read back as zero: no readback path exists
  always_comb begin
    case (ptr)
      FREQ_LOW_ADDR: tx_next = freq_hold[7:0];
      FREQ_MID_ADDR: tx_next = freq_hold[15:8];
      FREQ_HIGH_ADDR: tx_next = {1'b0, freq_hold[FREQ_W-1:16]};
      RATE_ADDR: tx_next = rate_hold[RATE_W-1:1];
      STATUS_ADDR: tx_next = status_byte;
      default: tx_next = 8'h00;
    endcase
  end

  // ****************************************
  // Serial slave
  // ****************************************
  slave_state_type state;
  logic [3:0] bitcnt;
  logic [7:0] shreg, txreg, wr_addr, wr_data;
  logic wr_en, sda_drive;

  assign link.sda_out_device = 1'b0;
  assign link.sda_oe_device = sda_drive;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= SL_IDLE;
      bitcnt <= 4'h0;
      shreg <= 8'h00;
      txreg <= 8'h00;
      ptr <= 8'h00;
      wr_addr <= 8'h00;
      wr_data <= 8'h00;
      wr_en <= 1'b0;
      sda_drive <= 1'b0;
    end else begin
      wr_en <= 1'b0;
      if (bus_start) begin
        state <= SL_ADDR;
        // The start's own clock fall wraps this to zero, so eight rises fill a byte
        bitcnt <= '1;
        sda_drive <= 1'b0;
      end else if (bus_stop) begin
        state <= SL_IDLE;
        sda_drive <= 1'b0;
      end else if (state != SL_IDLE && scl_rise) begin
        if (bitcnt != ACK_BIT) begin
          shreg <= {shreg[6:0], sda_s};
        end else if (state == SL_SEND && sda_s) begin
          state <= SL_IDLE;
        end
      end else if (state != SL_IDLE && scl_fall) begin
        if (bitcnt == ACK_BIT) begin
          bitcnt <= 4'h0;
          sda_drive <= 1'b0;
          if (state == SL_SEND) begin
            txreg <= tx_next;
            sda_drive <= ~tx_next[7];
            ptr <= ptr + 8'h01;
          end
        end else if (bitcnt == BYTE_LAST_BIT) begin
          bitcnt <= ACK_BIT;
          case (state)
            SL_ADDR: begin
              if (shreg[7:1] == my_addr) begin
                sda_drive <= 1'b1;
                state <= shreg[0] ? SL_SEND : SL_REG;
              end else begin
                state <= SL_IDLE;
              end
            end
            SL_REG: begin
              ptr <= shreg;
              sda_drive <= 1'b1;
              state <= SL_DATA;
            end
            SL_DATA: begin
              wr_en <= 1'b1;
              wr_addr <= ptr;
              wr_data <= shreg;
              ptr <= ptr + 8'h01;
              sda_drive <= 1'b1;
            end
            SL_SEND: sda_drive <= 1'b0;
            default: state <= SL_IDLE;
          endcase
        end else begin
          bitcnt <= bitcnt + 4'h1;
          if (state == SL_SEND) begin
            txreg <= {txreg[6:0], 1'b0};
            sda_drive <= ~txreg[6];
          end
        end
      end
    end
  end

  // ****************************************
  // Control writes and status flags
  // ****************************************
  function automatic logic fell(input logic [7:0] old_v, input logic [7:0] new_v, input int b);
    return old_v[b] & ~new_v[b];
  endfunction

  logic wr_a, wr_b, wr_c, clr_latch, clr_done, start_req;
  assign wr_a = wr_en && wr_addr == REFERENCE_AND_MEASURE_CTRL_ADDR;
  assign wr_b = wr_en && wr_addr == LOCK_PIN_AND_RESET_CTRL_ADDR;
  assign wr_c = wr_en && wr_addr == SIGNAL_PIN_AND_SQUELCH_CTRL_ADDR;
  assign clr_latch = wr_b && fell(lock_pin_and_reset_ctrl, wr_data, CLR_LATCH_BIT);
  assign clr_done = wr_b && fell(lock_pin_and_reset_ctrl, wr_data, CLR_DONE_BIT);
  assign start_req = wr_a && wr_data[MEASURE_BIT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reference_and_measure_ctrl <= CTRL_RESET;
      lock_pin_and_reset_ctrl <= CTRL_RESET;
      signal_pin_and_squelch_ctrl <= CTRL_RESET;
      soft_reset <= 1'b0;
    end else if (soft_reset) begin
      reference_and_measure_ctrl <= CTRL_RESET;
      lock_pin_and_reset_ctrl <= CTRL_RESET;
      signal_pin_and_squelch_ctrl <= CTRL_RESET;
      soft_reset <= 1'b0;
    end else begin
      if (wr_a) reference_and_measure_ctrl <= wr_data;
      if (wr_b) lock_pin_and_reset_ctrl <= wr_data;
      if (wr_c) signal_pin_and_squelch_ctrl <= wr_data;
      soft_reset <= wr_b && fell(lock_pin_and_reset_ctrl, wr_data, SYS_RESET_BIT);
    end
  end

  // Analog readback is assumed settled when the done pin rises
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_flag <= 1'b0;
      freq_hold <= '0;
      rate_hold <= '0;
      measure_start <= 1'b0;
    end else if (soft_reset) begin
      done_flag <= 1'b0;
      freq_hold <= '0;
      rate_hold <= '0;
      measure_start <= 1'b0;
    end else begin
      measure_start <= start_req;
      if (start_req || clr_done) done_flag <= 1'b0;
      if (done_rise) begin
        done_flag <= 1'b1;
        freq_hold <= freq_count;
        rate_hold <= coarse_rate;
      end
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latched_lol <= 1'b0;
    end else if (soft_reset) begin
      latched_lol <= 1'b0;
    end else begin
      if (clr_latch) latched_lol <= 1'b0;
      if (acq_rise) latched_lol <= 1'b1;
    end
  end

  // ****************************************
  // Output pins
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_lost <= 1'b0;
      signal_lost <= 1'b0;
      clock_out_enable <= 1'b1;
      data_out_enable <= 1'b1;
      system_reset <= 1'b0;
    end else begin
      lock_lost <= lock_pin_and_reset_ctrl[LOL_CFG_BIT] ? latched_lol : acquiring_s;
      signal_lost <= absent_s ^ signal_pin_and_squelch_ctrl[LOS_POL_BIT];
      clock_out_enable <= ~squelch_s;
      data_out_enable <= ~(squelch_s & ~signal_pin_and_squelch_ctrl[SQUELCH_MODE_BIT]);
      system_reset <= soft_reset;
    end
  end

  assign lock_to_reference = reference_and_measure_ctrl[LOCK_REF_BIT];
  assign reference_band = reference_and_measure_ctrl[BAND_MSB:BAND_LSB];
  assign rate_ratio_exp = reference_and_measure_ctrl[RATIO_MSB:RATIO_LSB];

endmodule // cdr_mgmt_device
`default_nettype wire

// file: core/cdr_mgmt_host.sv
`timescale 1ns/1ns
`default_nettype none
module cdr_mgmt_host
  import cdr_mgmt_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  cdr_link_if.host link,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  // ****************************************
  // Register slave
  // ****************************************
  logic [31:0] cmd;
  logic busy, nack, go;
  logic [7:0] rdata;
  logic [31:0] status_word;

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[HOST_BUSY_BIT] = busy;
    status_word[HOST_NACK_BIT] = nack;
    status_word[HOST_RDATA_LSB +: 8] = rdata;
  end

  // A command written while busy is dropped; software polls busy first
  assign go = psel && penable && pready && pwrite && paddr == HOST_CMD_OFFSET && !busy;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      cmd <= 32'h0000_0000;
    end else begin
      pready <= psel && penable && !pready;
      if (psel && penable && !pready) begin
        case (paddr)
          HOST_CMD_OFFSET: prdata <= cmd;
          HOST_STATUS_OFFSET: prdata <= status_word;
          default: prdata <= 32'h0000_0000;
        endcase
      end
      if (go) cmd <= pwdata;
    end
  end

  // ****************************************
  // Serial master
  // ****************************************
  logic [1:0] sda_meta;
  logic sda_s;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sda_meta <= 2'h3;
    end else begin
      sda_meta <= {sda_meta[0], link.sda};
    end
  end
  assign sda_s = sda_meta[1];

  master_state_type state;
  logic [QUARTER_W-1:0] qcnt;
  logic [1:0] phase, byte_idx;
  logic [3:0] bitcnt;
  logic [7:0] shreg, reg_addr, wdata;
  logic is_read, pulse_pending, scl_low, sda_low;
  logic [6:0] target;
  logic [7:0] masked;
  logic tick;

  assign tick = qcnt == QUARTER_W'(QUARTER_CYCLES - 1);
  assign link.scl_out_host = 1'b0;
  assign link.scl_oe_host = scl_low;
  assign link.sda_out_host = 1'b0;
  assign link.sda_oe_host = sda_low;

  always_comb begin
    target = SLAVE_ADDR_BASE;
    target[SLAVE_ADDR_SEL_BIT] = pwdata[CMD_ADDR_SEL_BIT];
    masked = pwdata[CMD_DATA_LSB +: 8];
    if (pwdata[7:0] == LOCK_PIN_AND_RESET_CTRL_ADDR) masked = masked & ~LOCK_PIN_AND_RESET_CTRL_RESERVED_MASK;
    if (pwdata[7:0] == SIGNAL_PIN_AND_SQUELCH_CTRL_ADDR) masked = masked & ~SIGNAL_PIN_AND_SQUELCH_CTRL_RESERVED_MASK;
  end

  logic [6:0] slave;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= M_IDLE;
      qcnt <= '0;
      phase <= 2'h0;
      byte_idx <= 2'h0;
      bitcnt <= 4'h0;
      shreg <= 8'h00;
      reg_addr <= 8'h00;
      wdata <= 8'h00;
      slave <= 7'h00;
      is_read <= 1'b0;
      pulse_pending <= 1'b0;
      scl_low <= 1'b0;
      sda_low <= 1'b0;
      busy <= 1'b0;
      nack <= 1'b0;
      rdata <= 8'h00;
    end else if (!busy) begin
      if (go) begin
        busy <= 1'b1;
        nack <= 1'b0;
        state <= M_START;
        qcnt <= '0;
        phase <= 2'h0;
        slave <= target;
        reg_addr <= pwdata[7:0];
        wdata <= masked;
        is_read <= pwdata[CMD_READ_BIT];
        pulse_pending <= pwdata[CMD_PULSE_BIT] & ~pwdata[CMD_READ_BIT];
      end
    end else begin
      qcnt <= tick ? '0 : qcnt + QUARTER_W'(1);
      if (tick) begin
        phase <= phase + 2'h1;
        case (state)
          M_START: begin
            case (phase)
              2'h0: begin sda_low <= 1'b0; scl_low <= 1'b0; end
              2'h1: sda_low <= 1'b1;
              2'h2: scl_low <= 1'b1;
              default: begin
                state <= M_SEND;
                bitcnt <= 4'h0;
                byte_idx <= 2'h0;
                shreg <= {slave, 1'b0};
              end
            endcase
          end
          M_SEND: begin
            case (phase)
              2'h0: sda_low <= (bitcnt == ACK_BIT) ? 1'b0 : ~shreg[7];
              2'h1: scl_low <= 1'b0;
              2'h2: if (bitcnt == ACK_BIT && sda_s) nack <= 1'b1;
              default: begin
                scl_low <= 1'b1;
                if (bitcnt != ACK_BIT) begin
                  bitcnt <= bitcnt + 4'h1;
                  shreg <= {shreg[6:0], 1'b0};
                end else begin
                  bitcnt <= 4'h0;
                  if (nack) state <= M_STOP;
                  else begin
                    case (byte_idx)
                      2'h0: begin shreg <= reg_addr; byte_idx <= 2'h1; end
                      2'h1: begin
                        if (is_read) state <= M_RESTART;
                        else begin shreg <= wdata; byte_idx <= 2'h2; end
                      end
                      2'h3: state <= M_RECV;
                      default: state <= M_STOP;
                    endcase
                  end
                end
              end
            endcase
          end
          M_RESTART: begin
            case (phase)
              2'h0: sda_low <= 1'b0;
              2'h1: scl_low <= 1'b0;
              2'h2: sda_low <= 1'b1;
              default: begin
                scl_low <= 1'b1;
                state <= M_SEND;
                shreg <= {slave, 1'b1};
                byte_idx <= 2'h3;
              end
            endcase
          end
          M_RECV: begin
            case (phase)
              2'h0: sda_low <= 1'b0;
              2'h1: scl_low <= 1'b0;
              2'h2: if (bitcnt != ACK_BIT) shreg <= {shreg[6:0], sda_s};
              default: begin
                scl_low <= 1'b1;
                if (bitcnt == ACK_BIT) begin
                  state <= M_STOP;
                  rdata <= shreg;
                end else bitcnt <= bitcnt + 4'h1;
              end
            endcase
          end
          M_STOP: begin
            case (phase)
              2'h0: sda_low <= 1'b1;
              2'h1: scl_low <= 1'b0;
              2'h2: sda_low <= 1'b0;
              default: begin
                // Second pass drops the pulse bits: the one-then-zero sequence
                if (pulse_pending && !nack) begin
                  pulse_pending <= 1'b0;
                  wdata <= wdata & ~LOCK_PIN_AND_RESET_CTRL_PULSE_MASK;
                  state <= M_START;
                end else begin
                  busy <= 1'b0;
                  state <= M_IDLE;
                end
              end
            endcase
          end
          default: state <= M_IDLE;
        endcase
      end
    end
  end

endmodule // cdr_mgmt_host
`default_nettype wire

// file: testbench/cdr_link_properties.sv
`timescale 1ns/1ns
`default_nettype none
module cdr_link_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic scl,
  input wire logic squelch,
  input wire logic loop_acquiring,
  input wire logic input_signal_absent,
  input wire logic lock_lost,
  input wire logic signal_lost,
  input wire logic clock_out_enable,
  input wire logic data_out_enable,
  input wire logic lock_to_reference,
  input wire logic [1:0] reference_band,
  input wire logic [3:0] rate_ratio_exp,
  input wire logic measure_start,
  input wire logic system_reset
);
  // ****************************************
  // Device pin relations
  // ****************************************
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  squelch_clock_a: assert property (squelch [*5] |-> !clock_out_enable)
    else $error("clock output still enabled under squelch");
  unsquelch_both_a: assert property (!squelch [*5] |-> clock_out_enable && data_out_enable)
    else $error("outputs silenced without squelch");
  measure_pulse_a: assert property (measure_start |-> !scl ##1 !measure_start)
    else $error("measure start not a single pulse from the link");
  soft_reset_a: assert property (system_reset |-> !lock_to_reference && reference_band == 2'h0 ##1 !system_reset)
    else $error("system reset pulse wrong");
  reset_value_a: assert property ($rose(presetn) |-> !lock_to_reference && rate_ratio_exp == 4'h0 && reference_band == 2'h0)
    else $error("control fields not zero after reset");
  ctrl_on_link_a: assert property ($changed({lock_to_reference, reference_band, rate_ratio_exp}) |-> !scl)
    else $error("control field changed outside a link write");
  lock_rise_a: assert property ($rose(loop_acquiring) |-> ##[1:5] lock_lost)
    else $error("lock lost pin did not rise");
  signal_follow_a: assert property ($changed(input_signal_absent) |-> ##[1:5] $changed(signal_lost))
    else $error("signal lost pin did not follow");
endmodule // cdr_link_properties
`default_nettype wire

// file: testbench/tb_cdr_management_register_bank.sv
`timescale 1ns/1ns
`default_nettype none
module tb_cdr_management_register_bank;
  import cdr_mgmt_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, st;
  logic sel = 0, squelch = 0, absent = 0, acq = 0, mdone = 0, asel = 0;
  logic [22:0] fcnt = 23'h7a3c71;
  logic [8:0] crate = 9'h1a5;
  logic lock_lost, signal_lost, clk_en, dat_en, lock_ref, mstart, sreset;
  logic [1:0] band;
  logic [3:0] rexp;
  logic [7:0] wo_addr [3] = '{REFERENCE_AND_MEASURE_CTRL_ADDR, LOCK_PIN_AND_RESET_CTRL_ADDR, SIGNAL_PIN_AND_SQUELCH_CTRL_ADDR};
  logic [7:0] rb_exp [4] = '{8'h71, 8'h3c, 8'h7a, 8'hd2};
  int miscompares = 0, compares = 0, cycles = 0;
  always #10 pclk = ~pclk;
  cdr_link_if cdr_link_if_inst();
  cdr_mgmt_host cdr_mgmt_host_inst (.pclk(pclk), .presetn(presetn), .link(cdr_link_if_inst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  cdr_mgmt_device cdr_mgmt_device_inst (.pclk(pclk), .presetn(presetn), .link(cdr_link_if_inst),
    .slave_addr_bit_select(sel), .squelch(squelch), .input_signal_absent(absent),
    .loop_acquiring(acq), .measure_done(mdone), .freq_count(fcnt), .coarse_rate(crate),
    .lock_lost(lock_lost), .signal_lost(signal_lost), .clock_out_enable(clk_en),
    .data_out_enable(dat_en), .lock_to_reference(lock_ref), .reference_band(band),
    .rate_ratio_exp(rexp), .measure_start(mstart), .system_reset(sreset));
  cdr_link_properties cdr_link_properties_inst (.pclk(pclk), .presetn(presetn),
    .scl(cdr_link_if_inst.scl), .squelch(squelch), .loop_acquiring(acq),
    .input_signal_absent(absent), .lock_lost(lock_lost), .signal_lost(signal_lost),
    .clock_out_enable(clk_en), .data_out_enable(dat_en), .lock_to_reference(lock_ref),
    .reference_band(band), .rate_ratio_exp(rexp), .measure_start(mstart), .system_reset(sreset));
  task automatic report_and_stop;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    compares++;
    if (s !== e) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", n, e, s);
    end
  endtask
  // Samples pready at each rising edge; data is taken at the edge that sees it high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  // One link transfer through the command word, two for a write with p set, then poll until not busy
  task automatic dev(input logic [7:0] r, input logic [7:0] d, input logic rd, input logic p);
    logic [31:0] q;
    apb(1'b1, HOST_CMD_OFFSET, {13'h0, p, asel, rd, d, r}, q);
    st = 32'h1;
    for (int i = 0; i < 2000 && st[HOST_BUSY_BIT] !== 1'b0; i++) apb(1'b0, HOST_STATUS_OFFSET, 32'h0, st);
    @(negedge pclk);
  endtask
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      miscompares++;
      report_and_stop;
    end
  end
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(negedge pclk);
    chk("reset pins", 32'h3, {lock_ref, band, rexp, mstart, sreset, clk_en, dat_en});
    for (int i = 0; i < 4; i++) begin
      dev(REFERENCE_AND_MEASURE_CTRL_ADDR, {i[1:0], 1'b0, i[1:0], 1'b1, 1'b0, i[0]}, 1'b0, 1'b0);
      chk("reference_and_measure_ctrl fields", {i[1:0], 1'b0, i[1:0], 1'b1, i[0]}, {band, rexp, lock_ref});
    end
    dev(REFERENCE_AND_MEASURE_CTRL_ADDR, 8'h60, 1'b0, 1'b0);
    chk("ratio 256", 32'h8, rexp);
    foreach (wo_addr[k]) begin
      dev(wo_addr[k], 8'h0, 1'b1, 1'b0);
      chk("write only read", 32'h0, st[15:8]);
    end
    @(posedge pclk);
    absent <= 1'b1; acq <= 1'b1;
    dev(REFERENCE_AND_MEASURE_CTRL_ADDR, 8'h02, 1'b0, 1'b0);
    dev(STATUS_ADDR, 8'h0, 1'b1, 1'b0);
    chk("measuring", 32'h0, st[10]);
    @(posedge pclk);
    mdone <= 1'b1;
    repeat (10) @(posedge pclk);
    foreach (rb_exp[k]) begin
      dev(k[7:0], 8'h0, 1'b1, 1'b0);
      chk("readback", rb_exp[k], st[15:8]);
    end
    dev(STATUS_ADDR, 8'h0, 1'b1, 1'b0);
    chk("status all set", 32'h3d, st[15:8] & 8'h3d);
    @(posedge pclk);
    acq <= 1'b0;
    dev(STATUS_ADDR, 8'h0, 1'b1, 1'b0);
    chk("latched held", 32'h34, st[15:8] & 8'h3c);
    chk("live lock pin", 32'h0, lock_lost);
    dev(LOCK_PIN_AND_RESET_CTRL_ADDR, 8'h80, 1'b0, 1'b0);
    chk("latched lock pin", 32'h1, lock_lost);
    dev(LOCK_PIN_AND_RESET_CTRL_ADDR, 8'hc0, 1'b0, 1'b1);
    dev(LOCK_PIN_AND_RESET_CTRL_ADDR, 8'h88, 1'b0, 1'b1);
    chk("pin after clear", 32'h0, lock_lost);
    dev(STATUS_ADDR, 8'h0, 1'b1, 1'b0);
    chk("flags cleared", 32'h20, st[15:8] & 8'h3c);
    dev(SIGNAL_PIN_AND_SQUELCH_CTRL_ADDR, 8'h04, 1'b0, 1'b0);
    chk("active low loss", 32'h0, signal_lost);
    @(posedge pclk);
    squelch <= 1'b1;
    repeat (8) @(negedge pclk);
    chk("squelch both", 32'h0, {clk_en, dat_en});
    dev(SIGNAL_PIN_AND_SQUELCH_CTRL_ADDR, 8'h06, 1'b0, 1'b0);
    chk("squelch one", 32'h1, {clk_en, dat_en});
    @(posedge pclk);
    squelch <= 1'b0;
    dev(LOCK_PIN_AND_RESET_CTRL_ADDR, 8'h20, 1'b0, 1'b1);
    chk("after system reset", 32'h100, {signal_lost, band, rexp, lock_ref, lock_lost});
    @(posedge pclk);
    sel <= 1'b1;
    dev(STATUS_ADDR, 8'h0, 1'b1, 1'b0);
    chk("wrong address nack", 32'h1, st[HOST_NACK_BIT]);
    asel = 1'b1;
    dev(STATUS_ADDR, 8'h0, 1'b1, 1'b0);
    chk("matching address", 32'h0, st[HOST_NACK_BIT]);
    report_and_stop;
  end
endmodule // tb_cdr_management_register_bank
`default_nettype wire
